// file: core/actoc_core.sv
`timescale 1ns/10ps
module actoc_core #(
  parameter int W = 12,
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [NCH-1:0] reg_chan,
  output logic [7:0] reg_rdata,
  input wire logic [NCH-1:0][W-1:0] adc_data,
  output logic [NCH-1:0][W-1:0] out_data,
  output logic [NCH-1:0] out_oe_n,
  output logic sample_en,
  output logic dcs_active,
  output logic out_lvds,
  output logic out_interleave,
  output logic out_drive_low,
  output logic data_clock_out_invert,
  output logic [4:0] data_clock_out_delay
);

  logic [7:0] global_clock_config_reg;
  logic [7:0] clock_divide_ratio_reg;
  logic [7:0] clock_phase_config_reg;
  logic [7:0] data_clock_delay_reg;
  logic [NCH-1:0][7:0] output_test_pattern_reg;
  logic [NCH-1:0][7:0] channel_offset_trim_reg;
  logic [NCH-1:0][7:0] output_format_config_reg;
  logic [2:0] phase_cnt_reg;
  logic [2:0] div_cnt_reg;
  logic div_restart;
  logic [2:0] div_ratio;
  logic [7:0] rd_next;
  int rd_ch;

  assign div_ratio = clock_divide_ratio_reg[actoc_pkg::DIV_RATIO_LSB +:
    actoc_pkg::DIV_RATIO_W];
  assign div_restart = reg_wr && (reg_addr == actoc_pkg::ADDR_CLOCK_DIV ||
    reg_addr == actoc_pkg::ADDR_CLOCK_PHASE);

  // ------------------------------------------------------------
  // global registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      global_clock_config_reg <= actoc_pkg::RST_GLOBAL_CLOCK;
      clock_divide_ratio_reg <= actoc_pkg::RST_CLOCK_DIV;
      clock_phase_config_reg <= actoc_pkg::RST_CLOCK_PHASE;
      data_clock_delay_reg <= actoc_pkg::RST_CLK_OUT_DELAY;
    end
    else if (reg_wr)
    begin
      if (reg_addr == actoc_pkg::ADDR_GLOBAL_CLOCK)
        global_clock_config_reg <= reg_wdata & actoc_pkg::MASK_GLOBAL_CLOCK;
      if (reg_addr == actoc_pkg::ADDR_CLOCK_DIV)
        clock_divide_ratio_reg <= reg_wdata & actoc_pkg::MASK_CLOCK_DIV;
      if (reg_addr == actoc_pkg::ADDR_CLOCK_PHASE)
        clock_phase_config_reg <= reg_wdata & actoc_pkg::MASK_CLOCK_PHASE;
      if (reg_addr == actoc_pkg::ADDR_CLK_OUT_DELAY)
        data_clock_delay_reg <= reg_wdata & actoc_pkg::MASK_CLK_OUT_DELAY;
    end
  end

  // ------------------------------------------------------------
  // per-channel registers: a write lands in every selected channel
  // ------------------------------------------------------------
  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          output_test_pattern_reg[c] <= actoc_pkg::RST_TEST_PATTERN;
          channel_offset_trim_reg[c] <= actoc_pkg::RST_OFFSET_TRIM;
          output_format_config_reg[c] <= actoc_pkg::RST_OUT_FORMAT;
        end
        else if (reg_wr && reg_chan[c])
        begin
          if (reg_addr == actoc_pkg::ADDR_TEST_PATTERN)
            output_test_pattern_reg[c] <=
              reg_wdata & actoc_pkg::MASK_TEST_PATTERN;
          if (reg_addr == actoc_pkg::ADDR_OFFSET_TRIM)
            channel_offset_trim_reg[c] <=
              reg_wdata & actoc_pkg::MASK_OFFSET_TRIM;
          if (reg_addr == actoc_pkg::ADDR_OUT_FORMAT)
            output_format_config_reg[c] <=
              reg_wdata & actoc_pkg::MASK_OUT_FORMAT;
        end
      end

      actoc_pattern_gen #(
        .W(W)
      ) u_gen (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sample_en(sample_en),
        .adc_data(adc_data[c]),
        .test_cfg(output_test_pattern_reg[c]),
        .offset_cfg(channel_offset_trim_reg[c]),
        .format_cfg(output_format_config_reg[c]),
        .out_data(out_data[c])
      );

      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          out_oe_n[c] <= 1'b0;
        else
          out_oe_n[c] <=
            output_format_config_reg[c][actoc_pkg::FMT_OE_BAR_BIT];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // readback: lowest selected channel answers for local registers
  // ------------------------------------------------------------
  always_comb
  begin
    rd_ch = 0;
    for (int i = NCH - 1; i >= 0; i--)
      if (reg_chan[i])
        rd_ch = i;
    unique case (reg_addr)
      actoc_pkg::ADDR_GLOBAL_CLOCK: rd_next = global_clock_config_reg;
      actoc_pkg::ADDR_CLOCK_DIV: rd_next = clock_divide_ratio_reg;
      actoc_pkg::ADDR_TEST_PATTERN: rd_next = output_test_pattern_reg[rd_ch];
      actoc_pkg::ADDR_OFFSET_TRIM: rd_next = channel_offset_trim_reg[rd_ch];
      actoc_pkg::ADDR_OUT_FORMAT: rd_next = output_format_config_reg[rd_ch];
      actoc_pkg::ADDR_CLOCK_PHASE: rd_next = clock_phase_config_reg;
      actoc_pkg::ADDR_CLK_OUT_DELAY: rd_next = data_clock_delay_reg;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
  end

  // ------------------------------------------------------------
  // input clock divider with phase slip
  // ------------------------------------------------------------
  // a write to ratio or phase restarts the divider, so the slip is
  // measured from a known point rather than from an arbitrary count
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_cnt_reg <= 3'h0;
      div_cnt_reg <= 3'h0;
      sample_en <= 1'b0;
    end
    else if (div_restart)
    begin
      phase_cnt_reg <= (reg_addr == actoc_pkg::ADDR_CLOCK_PHASE) ?
        reg_wdata[actoc_pkg::PHASE_LSB +: actoc_pkg::PHASE_W] :
        clock_phase_config_reg[actoc_pkg::PHASE_LSB +:
          actoc_pkg::PHASE_W];
      div_cnt_reg <= 3'h0;
      sample_en <= 1'b0;
    end
    else if (phase_cnt_reg != 3'h0)
    begin
      phase_cnt_reg <= phase_cnt_reg - 3'h1;
      sample_en <= 1'b0;
    end
    else if (div_cnt_reg == div_ratio)
    begin
      div_cnt_reg <= 3'h0;
      sample_en <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
      sample_en <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // clock and output configuration levels
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dcs_active <= 1'b1;
      out_lvds <= 1'b0;
      out_interleave <= 1'b0;
      out_drive_low <= 1'b0;
      data_clock_out_invert <= 1'b0;
      data_clock_out_delay <= 5'h00;
    end
    else
    begin
      dcs_active <= global_clock_config_reg[actoc_pkg::DCS_EN_BIT] ||
        (div_ratio != 3'h0);
      out_lvds <= output_format_config_reg[0][actoc_pkg::FMT_LVDS_BIT];
      out_interleave <=
        output_format_config_reg[0][actoc_pkg::FMT_INTERLEAVE_BIT];
      out_drive_low <= output_format_config_reg[0][actoc_pkg::FMT_DRIVE_BIT];
      data_clock_out_invert <=
        clock_phase_config_reg[actoc_pkg::CLK_OUT_INVERT_BIT];
      data_clock_out_delay <=
        data_clock_delay_reg[actoc_pkg::CLK_OUT_DELAY_LSB +:
        actoc_pkg::CLK_OUT_DELAY_W];
    end
  end

endmodule

// file: core/actoc_pattern_gen.sv
`timescale 1ns/10ps
module actoc_pattern_gen #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sample_en,
  input wire logic [W-1:0] adc_data,
  input wire logic [7:0] test_cfg,
  input wire logic [7:0] offset_cfg,
  input wire logic [7:0] format_cfg,
  output logic [W-1:0] out_data
);

  localparam int LL = actoc_pkg::PRN_LONG_LEN;
  localparam int SL = actoc_pkg::PRN_SHORT_LEN;
  localparam logic [W-1:0] MIDSCALE = {1'b1, {(W-1){1'b0}}};
  localparam logic [W-1:0] POS_FULL = {W{1'b1}};
  localparam logic [W-1:0] NEG_FULL = {W{1'b0}};
  localparam logic [W-1:0] CHECKER = {(W/2){2'b10}};
  localparam logic signed [W+1:0] MAX_CODE = {2'b00, {W{1'b1}}};

  actoc_pkg::actoc_pattern_t sel;
  actoc_pkg::actoc_format_t fmt;
  logic [LL-1:0] prn_long_reg;
  logic [SL-1:0] prn_short_reg;
  logic phase_reg;
  logic signed [W+1:0] trimmed;
  logic [W-1:0] normal_code;
  logic [W-1:0] out_next;

  assign sel = actoc_pkg::actoc_pattern_t'(
    test_cfg[actoc_pkg::TP_SEL_LSB +: actoc_pkg::TP_SEL_W]);
  assign fmt = actoc_pkg::actoc_format_t'(
    format_cfg[actoc_pkg::FMT_LSB +: actoc_pkg::FMT_W]);

  // ------------------------------------------------------------
  // pattern sequencers, advanced once per output sample
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      phase_reg <= 1'b0;
    else if (sample_en)
      phase_reg <= ~phase_reg;
  end

  // the reset bits hold the generator at its seed for as long as set
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      prn_long_reg <= {LL{1'b1}};
    else if (test_cfg[actoc_pkg::TP_RST_LONG_BIT])
      prn_long_reg <= {LL{1'b1}};
    else if (sample_en)
      prn_long_reg <= {prn_long_reg[LL-2:0],
        prn_long_reg[LL-1] ^ prn_long_reg[actoc_pkg::PRN_LONG_TAP-1]};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      prn_short_reg <= {SL{1'b1}};
    else if (test_cfg[actoc_pkg::TP_RST_SHORT_BIT])
      prn_short_reg <= {SL{1'b1}};
    else if (sample_en)
      prn_short_reg <= {prn_short_reg[SL-2:0],
        prn_short_reg[SL-1] ^ prn_short_reg[actoc_pkg::PRN_SHORT_TAP-1]};
  end

  // ------------------------------------------------------------
  // normal path: offset trim with saturation, offset binary in
  // ------------------------------------------------------------
  always_comb
  begin
    trimmed = $signed({2'b00, adc_data}) + $signed({{(W-4){
      offset_cfg[actoc_pkg::OFFSET_W-1]}},
      offset_cfg[actoc_pkg::OFFSET_LSB +: actoc_pkg::OFFSET_W]});
    if (trimmed < 0)
      normal_code = NEG_FULL;
    else if (trimmed > MAX_CODE)
      normal_code = POS_FULL;
    else
      normal_code = trimmed[W-1:0];
  end

  // ------------------------------------------------------------
  // word select; bit patterns bypass the code format but still take the invert
  // ------------------------------------------------------------
  function automatic logic [W-1:0] apply_fmt(input logic [W-1:0] code,
    input actoc_pkg::actoc_format_t f);
    logic [W-1:0] r;
    r = code;
    if (f == actoc_pkg::FMT_TWOS)
      r = {~code[W-1], code[W-2:0]};
    else if (f == actoc_pkg::FMT_GRAY)
      r = code ^ (code >> 1);
    return r;
  endfunction

  always_comb
  begin
    out_next = apply_fmt(normal_code, fmt);
    unique case (sel)
      actoc_pkg::TP_OFF:
        out_next = apply_fmt(normal_code, fmt);
      actoc_pkg::TP_MIDSCALE:
        out_next = apply_fmt(MIDSCALE, fmt);
      actoc_pkg::TP_POS_FULL_SCALE:
        out_next = apply_fmt(POS_FULL, fmt);
      actoc_pkg::TP_NEG_FULL_SCALE:
        out_next = apply_fmt(NEG_FULL, fmt);
      actoc_pkg::TP_CHECKER:
        out_next = phase_reg ? ~CHECKER : CHECKER;
      actoc_pkg::TP_PRN_LONG:
        out_next = prn_long_reg[W-1:0];
      actoc_pkg::TP_PRN_SHORT:
        out_next = {{(W-SL){1'b0}}, prn_short_reg};
      actoc_pkg::TP_WORD_TOGGLE:
        out_next = phase_reg ? NEG_FULL : POS_FULL;
    endcase
    if (format_cfg[actoc_pkg::FMT_INVERT_BIT])
      out_next = ~out_next;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      out_data <= {W{1'b0}};
    else if (sample_en)
      out_data <= out_next;
  end

endmodule

// file: core/actoc_pkg.sv
package actoc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_CLOCK = 8'h09;
  localparam logic [7:0] ADDR_CLOCK_DIV = 8'h0B;
  localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0D;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_CLOCK_PHASE = 8'h16;
  localparam logic [7:0] ADDR_CLK_OUT_DELAY = 8'h17;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] RST_CLOCK_DIV = 8'h00;
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_CLOCK_PHASE = 8'h00;
  localparam logic [7:0] RST_CLK_OUT_DELAY = 8'h00;

  // ------------------------------------------------------------
  // implemented bits per register; open bits read as zero
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] MASK_CLOCK_DIV = 8'h07;
  localparam logic [7:0] MASK_TEST_PATTERN = 8'h37;
  localparam logic [7:0] MASK_OFFSET_TRIM = 8'h3F;
  localparam logic [7:0] MASK_OUT_FORMAT = 8'hF7;
  localparam logic [7:0] MASK_CLOCK_PHASE = 8'h87;
  localparam logic [7:0] MASK_CLK_OUT_DELAY = 8'h1F;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DCS_EN_BIT = 0;
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_RATIO_W = 3;
  localparam int TP_SEL_LSB = 0;
  localparam int TP_SEL_W = 3;
  localparam int TP_RST_SHORT_BIT = 4;
  localparam int TP_RST_LONG_BIT = 5;
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_W = 6;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 2;
  localparam int FMT_INVERT_BIT = 2;
  localparam int FMT_OE_BAR_BIT = 4;
  localparam int FMT_INTERLEAVE_BIT = 5;
  localparam int FMT_LVDS_BIT = 6;
  localparam int FMT_DRIVE_BIT = 7;
  localparam int PHASE_LSB = 0;
  localparam int PHASE_W = 3;
  localparam int CLK_OUT_INVERT_BIT = 7;
  localparam int CLK_OUT_DELAY_LSB = 0;
  localparam int CLK_OUT_DELAY_W = 5;

  // ------------------------------------------------------------
  // pseudo_random generator lengths and taps
  // ------------------------------------------------------------
  localparam int PRN_LONG_LEN = 23;
  localparam int PRN_LONG_TAP = 18;
  localparam int PRN_SHORT_LEN = 9;
  localparam int PRN_SHORT_TAP = 5;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TP_OFF = 3'h0,
    TP_MIDSCALE = 3'h1,
    TP_POS_FULL_SCALE = 3'h2,
    TP_NEG_FULL_SCALE = 3'h3,
    TP_CHECKER = 3'h4,
    TP_PRN_LONG = 3'h5,
    TP_PRN_SHORT = 3'h6,
    TP_WORD_TOGGLE = 3'h7
  } actoc_pattern_t;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2,
    FMT_OFFSET_BIN2 = 2'h3
  } actoc_format_t;

endpackage

// file: verification/actoc_checker.sv
`timescale 1ns/10ps
module actoc_checker #(
  parameter int W = 12,
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [NCH-1:0] reg_chan,
  input wire logic [NCH-1:0][W-1:0] out_data,
  input wire logic [NCH-1:0] out_oe_n,
  input wire logic sample_en,
  input wire logic dcs_active,
  input wire logic data_clock_out_invert,
  input wire logic [4:0] data_clock_out_delay
);
  // ------------------------------------------------------------
  // shadow of written registers and strobe schedule
  // ------------------------------------------------------------
  logic g_reg;
  logic [2:0] r_reg, ta_reg;
  logic [7:0] p_reg, fa_reg, fb_reg;
  logic [4:0] d_reg, since_reg, due_reg;
  logic restart, dcs_exp;
  logic [2:0] nr, np;
  logic [1:0] oe_exp;
  logic [5:0] clk_out_exp;
  assign restart = reg_wr && (reg_addr == 8'h0B || reg_addr == 8'h16);
  assign nr = (reg_wr && reg_addr == 8'h0B) ? reg_wdata[2:0] : r_reg;
  assign np = (reg_wr && reg_addr == 8'h16) ? reg_wdata[2:0] : p_reg[2:0];
  assign dcs_exp = g_reg || r_reg != 3'h0;
  assign oe_exp = {fb_reg[4], fa_reg[4]};
  assign clk_out_exp = {p_reg[7], d_reg};
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      g_reg <= 1'b1;
      r_reg <= 3'h0;
      ta_reg <= 3'h0;
      p_reg <= 8'h00;
      fa_reg <= 8'h00;
      fb_reg <= 8'h00;
      d_reg <= 5'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        8'h09: g_reg <= reg_wdata[0];
        8'h0B: r_reg <= reg_wdata[2:0];
        8'h0D: if (reg_chan[0]) ta_reg <= reg_wdata[2:0];
        8'h14:
        begin
          if (reg_chan[0]) fa_reg <= reg_wdata;
          if (reg_chan[1]) fb_reg <= reg_wdata;
        end
        8'h16: p_reg <= reg_wdata;
        8'h17: d_reg <= reg_wdata[4:0];
        default: ;
      endcase
    end
  // a restart clears the strobe, so the cycle right after it carries no
  // pulse; the schedule is only judged once the new count has started
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      since_reg <= 5'h00;
      due_reg <= 5'h01;
    end
    else if (restart)
    begin
      since_reg <= 5'h00;
      due_reg <= {2'h0, nr} + {2'h0, np} + 5'h01;
    end
    else if (sample_en && since_reg != 5'h00)
    begin
      since_reg <= 5'h01;
      due_reg <= {2'h0, r_reg} + 5'h01;
    end
    else
      since_reg <= since_reg + 5'h01;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  strobe_sched_a: assert property (
    since_reg != 5'h00 |-> sample_en == (since_reg == due_reg))
    else $error("sample strobe off schedule");
  dcs_force_a: assert property (dcs_active == $past(dcs_exp))
    else $error("stabilizer state wrong");
  word_hold_a: assert property (!sample_en |=> $stable(out_data))
    else $error("output word moved without strobe");
  oe_follow_a: assert property (out_oe_n == $past(oe_exp))
    else $error("output enable wrong");
  clk_out_follow_a: assert property (
    {data_clock_out_invert, data_clock_out_delay} == $past(clk_out_exp))
    else $error("clock out settings wrong");
  midscale_word_a: assert property (
    sample_en && ta_reg == 3'h1 && fa_reg[2:0] == 3'h0
    |=> out_data[0] == 12'h800) else $error("midscale word wrong");
  full_scale_a: assert property (
    sample_en && ta_reg[2:1] == 2'h1 && fa_reg[2:0] == 3'h0
    |=> out_data[0] == ($past(ta_reg[0]) ? 12'h000 : 12'hFFF))
    else $error("full scale word wrong");
  checker_word_a: assert property (
    (sample_en && ta_reg == 3'h4 && !fa_reg[2]) [*2]
    |=> (out_data[0] == 12'hAAA || out_data[0] == 12'h555)
    && out_data[0] == ~$past(out_data[0])) else $error("checkerboard wrong");
endmodule
bind actoc_core actoc_checker #(.W(W), .NCH(NCH)) chk (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_chan(reg_chan),
  .out_data(out_data),
  .out_oe_n(out_oe_n),
  .sample_en(sample_en),
  .dcs_active(dcs_active),
  .data_clock_out_invert(data_clock_out_invert),
  .data_clock_out_delay(data_clock_out_delay)
);

// file: verification/actoc_core_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", n, e, g); \
    end \
  end
module actoc_core_tb;
  logic core_clk, arst_n, reg_wr, reg_rd, sample_en, dcs_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] reg_chan, out_oe_n;
  logic [1:0][11:0] adc_data, out_data;
  logic out_lvds, out_interleave, out_drive_low;
  logic [11:0] w1, w2;
  int failures, total_checks;
  localparam logic [7:0] ADDRS [7] = '{8'h09, 8'h0B, 8'h0D, 8'h10, 8'h14,
    8'h16, 8'h17};
  localparam logic [7:0] RSTV [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  localparam logic [7:0] MASKS [7] = '{8'h01, 8'h07, 8'h37, 8'h3F, 8'hF7,
    8'h87, 8'h1F};
  localparam int RT [4] = '{0, 3, 7, 1};
  localparam int PH [4] = '{0, 5, 7, 2};
  localparam logic [11:0] CW [4] = '{12'h123, 12'h800, 12'hFFF, 12'h000};
  actoc_core #(.W(12), .NCH(2)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_chan(reg_chan), .reg_rdata(reg_rdata), .adc_data(adc_data),
    .out_data(out_data), .out_oe_n(out_oe_n), .sample_en(sample_en),
    .dcs_active(dcs_active), .out_lvds(out_lvds),
    .out_interleave(out_interleave), .out_drive_low(out_drive_low),
    .data_clock_out_invert(), .data_clock_out_delay()
  );
  actoc_host host (
    .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_chan(reg_chan),
    .reg_rdata(reg_rdata)
  );
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task end_of_test;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_regs;
    logic [7:0] v;
    for (int i = 0; i < 7; i++)
    begin
      host.rd(ADDRS[i], 2'h1, v);
      `CHK("reset value", RSTV[i], v)
      host.wr(ADDRS[i], 8'hFF, 2'h3);
      host.rd(ADDRS[i], 2'h1, v);
      `CHK("open bits", MASKS[i], v)
      host.wr(ADDRS[i], RSTV[i], 2'h3);
    end
    host.wr(8'h20, 8'hFF, 2'h3);
    host.rd(8'h20, 2'h1, v);
    `CHK("unmapped", 8'h00, v)
  endtask
  task t_dcs;
    host.wr(8'h09, 8'h00, 2'h1);
    @(posedge core_clk);
    #1;
    `CHK("dcs off", 1'b0, dcs_active)
    host.wr(8'h0B, 8'h03, 2'h1);
    @(posedge core_clk);
    #1;
    `CHK("dcs forced", 1'b1, dcs_active)
    host.wr(8'h0B, 8'h00, 2'h1);
    host.wr(8'h09, 8'h01, 2'h1);
  endtask
  task wait_strobe(output int k);
    for (k = 1; k < 40; k++)
    begin
      @(posedge core_clk);
      #1;
      if (sample_en === 1'b1) break;
    end
  endtask
  task t_div;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      host.wr(8'h16, PH[i][7:0], 2'h1);
      host.wr(8'h0B, RT[i][7:0], 2'h1);
      wait_strobe(k);
      `CHK("first strobe", RT[i] + PH[i] + 1, k)
      wait_strobe(k);
      `CHK("strobe period", RT[i] + 1, k)
    end
    host.wr(8'h0B, 8'h00, 2'h1);
    host.wr(8'h16, 8'h00, 2'h1);
  endtask
  // ratio is 0 here, so every cycle carries a fresh word
  task pair(input logic [7:0] mode);
    host.wr(8'h0D, mode, 2'h1);
    repeat (3) @(posedge core_clk);
    #1;
    w1 = out_data[0];
    @(posedge core_clk);
    #1;
    w2 = out_data[0];
  endtask
  task t_pat;
    for (int i = 0; i < 4; i++)
    begin
      pair(i[7:0]);
      `CHK("constant word", CW[i], w1)
      `CHK("other channel", 12'h456, out_data[1])
    end
    pair(8'h04);
    `CHK("checker pair", 12'hFFF, w1 ^ w2)
    `CHK("checker word", 1'b1, w1 === 12'hAAA || w1 === 12'h555)
    pair(8'h07);
    `CHK("toggle pair", 12'hFFF, w1 ^ w2)
    `CHK("toggle word", 1'b1, w1 === 12'hFFF || w1 === 12'h000)
    pair(8'h16);
    `CHK("short seed", 12'h1FF, w1)
    pair(8'h06);
    `CHK("short step", {3'h0, w1[7:0], w1[8] ^ w1[4]}, w2)
    pair(8'h25);
    `CHK("long seed", 12'hFFF, w1)
    pair(8'h05);
    `CHK("long step", w1[10:0], w2[11:1])
    pair(8'h00);
    `CHK("samples back", 12'h123, w2)
  endtask
  // offset trim, output formats, invert and the global output levels
  task t_fmt;
    logic [7:0] v;
    host.wr(8'h10, 8'h05, 2'h1);
    pair(8'h00);
    `CHK("offset trim", 12'h128, w1)
    host.wr(8'h14, 8'h01, 2'h1);
    pair(8'h00);
    `CHK("twos format", 12'h928, w1)
    host.wr(8'h14, 8'h02, 2'h1);
    pair(8'h01);
    `CHK("gray midscale", 12'hC00, w1)
    pair(8'h00);
    `CHK("gray format", 12'h1BC, w1)
    host.wr(8'h14, 8'hE4, 2'h1);
    pair(8'h00);
    `CHK("inverted word", 12'hED7, w1)
    `CHK("output type", 3'h7, {out_lvds, out_interleave, out_drive_low})
    host.rd(8'h14, 2'h2, v);
    `CHK("channel b format", 8'h00, v)
    host.wr(8'h14, 8'h00, 2'h1);
    host.wr(8'h10, 8'h00, 2'h1);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
  initial
  begin
    arst_n = 1'b0;
    adc_data = {12'h456, 12'h123};
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_dcs();
    t_div();
    t_pat();
    t_fmt();
    end_of_test();
  end
endmodule

// file: verification/actoc_host.sv
`timescale 1ns/10ps
module actoc_host (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] reg_chan,
  input wire logic [7:0] reg_rdata
);
  // ------------------------------------------------------------
  // register port master; released address and write data show inverted values
  // ------------------------------------------------------------
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, reg_chan} = 20'h1;
  end
  task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] c);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    reg_chan <= c;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task rd(input logic [7:0] a, input logic [1:0] c, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_chan <= c;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    #1;
    v = reg_rdata;
  endtask
endmodule
